// File: core/vdr_consts.svh
// Constants of the video decoder register bank: addresses, masks and reset values.
`ifndef VDR_CONSTS_SVH
`define VDR_CONSTS_SVH
`define VDR_ADDR_WR_DEF 8'h42
`define VDR_ADDR_RD_DEF 8'h43
`define VDR_ADDR_WR_ALT 8'h40
`define VDR_ADDR_RD_ALT 8'h41
`define VDR_OFS_CHIP_VERSION 8'h00
`define VDR_OFS_STATUS_ONE 8'h1E
`define VDR_OFS_STATUS_TWO 8'h1F
`define VDR_OFS_ANALOG_CTRL_A 8'h23
`define VDR_OFS_CH3_GAIN_LOW 8'h24
`define VDR_OFS_CH4_GAIN_LOW 8'h25
`define VDR_OFS_COMP_DELAY 8'h29
`define VDR_OFS_COMP_BRIGHT 8'h2A
`define VDR_OFS_COMP_CONTRAST 8'h2B
`define VDR_OFS_COMP_SAT 8'h2C
`define VDR_OFS_IRQ_MASK_1 8'h2D
`define VDR_OFS_IRQ_MASK_2 8'h2E
`define VDR_OFS_IRQ_MASK_3 8'h2F
`define VDR_OFS_AUDIO_CYCLES_PER_FIELD_LO 8'h30
`define VDR_OFS_AUDIO_CYCLES_PER_FIELD_MID 8'h31
`define VDR_OFS_AUDIO_CYCLES_PER_FIELD_HI 8'h32
`define VDR_OFS_AUDIO_NOMINAL_INCREMENT_LO 8'h34
`define VDR_OFS_AUDIO_NOMINAL_INCREMENT_MID 8'h35
`define VDR_OFS_AUDIO_NOMINAL_INCREMENT_HI 8'h36
`define VDR_OFS_BIT_DIV 8'h38
`define VDR_OFS_WORD_DIV 8'h39
`define VDR_OFS_AUDIO_SETUP 8'h3A
`define VDR_OFS_SLICER_ST0 8'h60
`define VDR_OFS_SLICER_ST2 8'h62
`define VDR_OFS_FRONT_FIRST 8'h01
`define VDR_OFS_FRONT_LAST 8'h19
`define VDR_OFS_SLICER_FIRST 8'h40
`define VDR_OFS_SLICER_LAST 8'h5E
`define VDR_OFS_SCALER_FIRST 8'h80
`define VDR_OFS_SCALER_LAST 8'hEF
`define VDR_MASK_FULL 8'hFF
`define VDR_MASK_NONE 8'h00
`define VDR_MASK_ANALOG_CTRL_A 8'hF7
`define VDR_MASK_IRQ_1 8'h1D
`define VDR_MASK_IRQ_2 8'h43
`define VDR_MASK_IRQ_3 8'hEF
`define VDR_MASK_AUDIO_CYCLES_PER_FIELD_HI 8'h03
`define VDR_MASK_SIX_BIT 8'h3F
`define VDR_MASK_AUDIO_SETUP 8'h0F
`define VDR_REG_RESET 8'h00
`define VDR_BIT_CNT_FULL 4'h8
`define VDR_BIT_CNT_LAST 4'h7
`define VDR_DIV_MIN 6'h02
`endif

// File: core/vdr_i2c_regs.sv
// Two-wire slave register bank of the video decoder with audio clock dividers.
// Functional notes
// R01 - Write address 42h, or 40h when strapped.
// R02 - Read address 43h, or 41h when strapped.
// R03 - Strap sampled after reset picks address pair.
// R04 - Pointer increments after every data byte.
// R05 - Slave acknowledges address, subaddress, data bytes.
// R06 - Master acknowledges read bytes, ends with stop.
// R07 - Write: start, address, subaddress, data, stop.
// R08 - Read: set subaddress, repeated start, read.
// R09 - Status bytes 1Eh, 1Fh are read only.
// R10 - Slicer status 60h to 62h read only.
// R11 - Ranges 80h to EFh read and write.
// R12 - 20h-2Fh: reserved holes, control bytes writable.
// R13 - Status byte one flag layout.
// R14 - Status byte two flag layout.
// R15 - Analog control byte 23h bit layout.
// R16 - Nine-bit gains from 24h/25h plus 23h.
// R17 - Eighteen-bit cycles per field, 30h-32h.
// R18 - Twenty-two-bit increment, 34h-36h, low first.
// R19 - Master clock divided by 38h ratio.
// R20 - Bit clock divided by 39h ratio.
// R21 - Audio setup bits at 3Ah.
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.svh"
module vdr_i2c_regs #(
  parameter logic [7:0] CHIP_VERSION = 8'h11 // Arbitrary version value.
) (
  input wire logic CLK_SYS, // System clock, 250 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic SCL_IN, // Bus clock level.
  input wire logic SDA_IN, // Bus data level.
  output logic SDA_OUT, // Bus data drive value, always low.
  output logic SDA_OE, // High while pulling data low.
  input wire logic REALTIME_CONTROL_OUTPUT_PIN, // Strap level read after reset.
  input wire logic HORIZONTAL_LOCK_FLAG, // Status one bit 6.
  input wire logic SLOW_TIME_CONSTANT_FLAG, // Status one bit 5.
  input wire logic GAIN_UPPER_LIMIT_FLAG, // Status one bit 4.
  input wire logic GAIN_LOWER_LIMIT_FLAG, // Status one bit 3.
  input wire logic WHITE_PEAK_FLAG, // Status one bit 2.
  input wire logic [1:0] DETECTED_STANDARD, // Status one bits 1:0.
  input wire logic INTERLACE_FLAG, // Status two bit 7.
  input wire logic HALF_LEVEL_FLAG, // Status two bit 6.
  input wire logic FIELD_FLAG, // Status two bit 5.
  input wire logic TYPE_FLAG, // Status two bit 3.
  input wire logic COLOR_STRIPE_FLAG, // Status two bit 2.
  input wire logic COPY_PROTECT_FLAG, // Status two bit 1.
  input wire logic READY_FLAG, // Status two bit 0.
  input wire logic [7:0] SLICER_STATUS_0, // Slicer status at 60h.
  input wire logic [7:0] SLICER_STATUS_1, // Slicer status at 61h.
  input wire logic [7:0] SLICER_STATUS_2, // Slicer status at 62h.
  input wire logic AUDIO_MASTER_CLOCK, // Audio master clock level.
  output logic ANALOG_OUTPUT_SELECT_BIT, // 23h bit 7.
  output logic CONVERTER_PORT_ENABLE, // 23h bit 6.
  output logic EXTERNAL_CLOCK_SELECT, // 23h bit 5.
  output logic REFERENCE_SELECT, // 23h bit 4.
  output logic EXTERNAL_CLAMP_ENABLE, // 23h bit 2.
  output logic [8:0] CHANNEL_THREE_GAIN, // Nine-bit gain, channel three.
  output logic [8:0] CHANNEL_FOUR_GAIN, // Nine-bit gain, channel four.
  output logic [17:0] AUDIO_CYCLES_PER_FIELD, // Master clocks per field.
  output logic [21:0] AUDIO_NOMINAL_INCREMENT, // Synthesis increment.
  output logic AUDIO_PLL_CONTROL, // 3Ah bit 3.
  output logic MASTER_CLOCK_MODE, // 3Ah bit 2.
  output logic AUDIO_BIT_CLOCK, // Divided serial bit clock.
  output logic AUDIO_WORD_CLOCK // Divided word clock.
);

  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic strap_done_ff;
  logic alt_addr_ff;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  vdr_pkg::vdr_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic mack_ok_ff;
  logic byte_done;
  logic wr_stb;
  logic [7:0] mem_ff [0:255];
  logic [7:0] status_one;
  logic [7:0] status_two;

  // Bus edge and condition detection on the previous sampled levels.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= SCL_IN;
      sda_d_ff <= SDA_IN;
    end
  end
  assign scl_rise = SCL_IN & ~scl_d_ff;
  assign scl_fall = ~SCL_IN & scl_d_ff;
  assign start_det = SCL_IN & scl_d_ff & sda_d_ff & ~SDA_IN;
  assign stop_det = SCL_IN & scl_d_ff & ~sda_d_ff & SDA_IN;

  // Strap is caught once, on the first edge after reset release.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      strap_done_ff <= 1'b0;
      alt_addr_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      alt_addr_ff <= REALTIME_CONTROL_OUTPUT_PIN; // R03
    end
  end
  assign wr_addr = alt_addr_ff ? `VDR_ADDR_WR_ALT : `VDR_ADDR_WR_DEF; // R01
  assign rd_addr = alt_addr_ff ? `VDR_ADDR_RD_ALT : `VDR_ADDR_RD_DEF; // R02

  // Status bytes assembled from the live decoder flags.
  assign status_one = {1'b0, HORIZONTAL_LOCK_FLAG, SLOW_TIME_CONSTANT_FLAG, // R13
    GAIN_UPPER_LIMIT_FLAG, GAIN_LOWER_LIMIT_FLAG, WHITE_PEAK_FLAG, DETECTED_STANDARD};
  assign status_two = {INTERLACE_FLAG, HALF_LEVEL_FLAG, FIELD_FLAG, 1'b0, // R14
    TYPE_FLAG, COLOR_STRIPE_FLAG, COPY_PROTECT_FLAG, READY_FLAG};

  // Writable bits per subaddress; zero marks read-only or reserved bytes.
  function automatic logic [7:0] wmask(input logic [7:0] a);
    logic [7:0] m;
    m = `VDR_MASK_NONE;
    if (a >= `VDR_OFS_FRONT_FIRST && a <= `VDR_OFS_FRONT_LAST) m = `VDR_MASK_FULL;
    if (a >= `VDR_OFS_SLICER_FIRST && a <= `VDR_OFS_SLICER_LAST) m = `VDR_MASK_FULL;
    if (a >= `VDR_OFS_SCALER_FIRST && a <= `VDR_OFS_SCALER_LAST) m = `VDR_MASK_FULL; // R11
    case (a)
      `VDR_OFS_ANALOG_CTRL_A: m = `VDR_MASK_ANALOG_CTRL_A; // R12 R15
      `VDR_OFS_CH3_GAIN_LOW, `VDR_OFS_CH4_GAIN_LOW: m = `VDR_MASK_FULL; // R12
      `VDR_OFS_COMP_DELAY, `VDR_OFS_COMP_BRIGHT: m = `VDR_MASK_FULL;
      `VDR_OFS_COMP_CONTRAST, `VDR_OFS_COMP_SAT: m = `VDR_MASK_FULL;
      `VDR_OFS_IRQ_MASK_1: m = `VDR_MASK_IRQ_1;
      `VDR_OFS_IRQ_MASK_2: m = `VDR_MASK_IRQ_2;
      `VDR_OFS_IRQ_MASK_3: m = `VDR_MASK_IRQ_3;
      `VDR_OFS_AUDIO_CYCLES_PER_FIELD_LO, `VDR_OFS_AUDIO_CYCLES_PER_FIELD_MID: m = `VDR_MASK_FULL; // R17
      `VDR_OFS_AUDIO_CYCLES_PER_FIELD_HI: m = `VDR_MASK_AUDIO_CYCLES_PER_FIELD_HI;
      `VDR_OFS_AUDIO_NOMINAL_INCREMENT_LO, `VDR_OFS_AUDIO_NOMINAL_INCREMENT_MID: m = `VDR_MASK_FULL; // R18
      `VDR_OFS_AUDIO_NOMINAL_INCREMENT_HI, `VDR_OFS_BIT_DIV, `VDR_OFS_WORD_DIV: m = `VDR_MASK_SIX_BIT;
      `VDR_OFS_AUDIO_SETUP: m = `VDR_MASK_AUDIO_SETUP; // R21
      default: m = m;
    endcase
    return m;
  endfunction : wmask

  // Read value per subaddress; reserved bytes read as zero.
  function automatic logic [7:0] rbyte(input logic [7:0] a);
    logic [7:0] v;
    v = mem_ff[a];
    case (a)
      `VDR_OFS_CHIP_VERSION: v = CHIP_VERSION;
      `VDR_OFS_STATUS_ONE: v = status_one; // R09
      `VDR_OFS_STATUS_TWO: v = status_two;
      `VDR_OFS_SLICER_ST0: v = SLICER_STATUS_0; // R10
      `VDR_OFS_SLICER_ST0 + 8'h01: v = SLICER_STATUS_1;
      `VDR_OFS_SLICER_ST2: v = SLICER_STATUS_2;
      default: v = v;
    endcase
    return v;
  endfunction : rbyte

  assign byte_done = scl_fall && (cnt_ff == `VDR_BIT_CNT_FULL);
  assign wr_stb = (state_ff == vdr_pkg::ST_WDATA) && byte_done;

  // Slave sequencer: address, subaddress, data and acknowledge phases.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_ff <= vdr_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      mack_ok_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= vdr_pkg::ST_ADDR; // Repeated start restarts addressing.
      cnt_ff <= 4'h0;
    end else if (stop_det) begin
      state_ff <= vdr_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        vdr_pkg::ST_ADDR, vdr_pkg::ST_SUB, vdr_pkg::ST_WDATA: begin
          if (scl_rise && cnt_ff != `VDR_BIT_CNT_FULL) begin
            shift_ff <= {shift_ff[6:0], SDA_IN};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_done) begin
            cnt_ff <= 4'h0;
            if (state_ff == vdr_pkg::ST_ADDR) begin
              if (shift_ff == wr_addr || shift_ff == rd_addr) begin // R01 R02
                state_ff <= vdr_pkg::ST_ACK_ADDR;
              end else begin
                state_ff <= vdr_pkg::ST_IDLE;
              end
            end else if (state_ff == vdr_pkg::ST_SUB) begin
              ptr_ff <= shift_ff;
              state_ff <= vdr_pkg::ST_ACK_SUB;
            end else begin
              ptr_ff <= ptr_ff + 8'h01; // R04
              state_ff <= vdr_pkg::ST_ACK_DATA;
            end
          end
        end
        vdr_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (shift_ff[0]) begin
              shift_ff <= rbyte(ptr_ff); // R08
              ptr_ff <= ptr_ff + 8'h01; // R04
              state_ff <= vdr_pkg::ST_RDATA;
            end else begin
              state_ff <= vdr_pkg::ST_SUB; // R07
            end
          end
        end
        vdr_pkg::ST_ACK_SUB, vdr_pkg::ST_ACK_DATA: begin
          if (scl_fall) begin
            state_ff <= vdr_pkg::ST_WDATA;
          end
        end
        vdr_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_ff == `VDR_BIT_CNT_LAST) begin
              cnt_ff <= 4'h0;
              state_ff <= vdr_pkg::ST_MACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        vdr_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_ok_ff <= ~SDA_IN; // R06
          end else if (scl_fall) begin
            if (mack_ok_ff) begin
              shift_ff <= rbyte(ptr_ff);
              ptr_ff <= ptr_ff + 8'h01; // R04
              state_ff <= vdr_pkg::ST_RDATA;
            end else begin
              state_ff <= vdr_pkg::ST_IDLE; // R06
            end
          end
        end
        default: state_ff <= vdr_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain drive: acknowledge slots and zero bits of read data.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = (state_ff == vdr_pkg::ST_ACK_ADDR) || (state_ff == vdr_pkg::ST_ACK_SUB) ||
    (state_ff == vdr_pkg::ST_ACK_DATA) || // R05
    ((state_ff == vdr_pkg::ST_RDATA) && !shift_ff[7]);

  // Register storage; only writable bits of writable bytes ever change.
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_mem
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          mem_ff[gi] <= `VDR_REG_RESET;
        end else if (wr_stb && ptr_ff == 8'(gi)) begin
          mem_ff[gi] <= shift_ff & wmask(8'(gi)); // R09 R10 R12
        end
      end
    end
  endgenerate

  // Control fields decoded from the stored bytes.
  assign ANALOG_OUTPUT_SELECT_BIT = mem_ff[`VDR_OFS_ANALOG_CTRL_A][7]; // R15
  assign CONVERTER_PORT_ENABLE = mem_ff[`VDR_OFS_ANALOG_CTRL_A][6];
  assign EXTERNAL_CLOCK_SELECT = mem_ff[`VDR_OFS_ANALOG_CTRL_A][5];
  assign REFERENCE_SELECT = mem_ff[`VDR_OFS_ANALOG_CTRL_A][4];
  assign EXTERNAL_CLAMP_ENABLE = mem_ff[`VDR_OFS_ANALOG_CTRL_A][2];
  assign CHANNEL_THREE_GAIN = {mem_ff[`VDR_OFS_ANALOG_CTRL_A][0],
    mem_ff[`VDR_OFS_CH3_GAIN_LOW]}; // R16
  assign CHANNEL_FOUR_GAIN = {mem_ff[`VDR_OFS_ANALOG_CTRL_A][1],
    mem_ff[`VDR_OFS_CH4_GAIN_LOW]}; // R16
  assign AUDIO_CYCLES_PER_FIELD = {mem_ff[`VDR_OFS_AUDIO_CYCLES_PER_FIELD_HI][1:0], mem_ff[`VDR_OFS_AUDIO_CYCLES_PER_FIELD_MID],
    mem_ff[`VDR_OFS_AUDIO_CYCLES_PER_FIELD_LO]}; // R17
  assign AUDIO_NOMINAL_INCREMENT = {mem_ff[`VDR_OFS_AUDIO_NOMINAL_INCREMENT_HI][5:0], mem_ff[`VDR_OFS_AUDIO_NOMINAL_INCREMENT_MID],
    mem_ff[`VDR_OFS_AUDIO_NOMINAL_INCREMENT_LO]}; // R18
  assign AUDIO_PLL_CONTROL = mem_ff[`VDR_OFS_AUDIO_SETUP][3]; // R21
  assign MASTER_CLOCK_MODE = mem_ff[`VDR_OFS_AUDIO_SETUP][2];

  // Audio dividers; ratios below two behave as two so the clocks never stall.
  logic am_d_ff;
  logic am_rise;
  logic [5:0] bit_ratio;
  logic [5:0] word_ratio;
  logic [5:0] bcnt_ff;
  logic [5:0] wcnt_ff;
  logic bclk_ff;
  logic wclk_ff;
  logic bclk_rise;
  assign bit_ratio = (mem_ff[`VDR_OFS_BIT_DIV][5:0] < `VDR_DIV_MIN) ? `VDR_DIV_MIN :
    mem_ff[`VDR_OFS_BIT_DIV][5:0];
  assign word_ratio = (mem_ff[`VDR_OFS_WORD_DIV][5:0] < `VDR_DIV_MIN) ? `VDR_DIV_MIN :
    mem_ff[`VDR_OFS_WORD_DIV][5:0];
  assign am_rise = AUDIO_MASTER_CLOCK & ~am_d_ff;
  assign bclk_rise = am_rise && (bcnt_ff == bit_ratio - 6'h01);

  // Bit clock: high for the first half, rounded down, of each ratio-long master period.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      am_d_ff <= 1'b0;
      bcnt_ff <= 6'h00;
      bclk_ff <= 1'b0;
    end else begin
      am_d_ff <= AUDIO_MASTER_CLOCK;
      if (am_rise) begin
        bcnt_ff <= bclk_rise ? 6'h00 : bcnt_ff + 6'h01; // R19
        bclk_ff <= bclk_rise || ((bcnt_ff + 6'h01) < (bit_ratio >> 1));
      end
    end
  end

  // Word clock: same scheme counted in bit clock periods.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wcnt_ff <= 6'h00;
      wclk_ff <= 1'b0;
    end else if (bclk_rise) begin
      wcnt_ff <= (wcnt_ff == word_ratio - 6'h01) ? 6'h00 : wcnt_ff + 6'h01; // R20
      wclk_ff <= (wcnt_ff == word_ratio - 6'h01) || ((wcnt_ff + 6'h01) < (word_ratio >> 1));
    end
  end
  assign AUDIO_BIT_CLOCK = bclk_ff ^ mem_ff[`VDR_OFS_AUDIO_SETUP][0]; // R21
  assign AUDIO_WORD_CLOCK = wclk_ff ^ mem_ff[`VDR_OFS_AUDIO_SETUP][1]; // R21

  // Checks on the slave sequencer and the register map.
  property p_wr_addr_ack;
    @(posedge CLK_SYS) disable iff (RST)
    (state_ff == vdr_pkg::ST_ADDR && byte_done && !start_det && !stop_det &&
     shift_ff == (alt_addr_ff ? 8'h40 : 8'h42)) |=> (state_ff == vdr_pkg::ST_ACK_ADDR) ##0 SDA_OE;
  endproperty
  a_wr_addr_ack: assert property (p_wr_addr_ack) else $error("write address not acknowledged"); // R01
  property p_rd_addr_ack;
    @(posedge CLK_SYS) disable iff (RST)
    (state_ff == vdr_pkg::ST_ADDR && byte_done && !start_det && !stop_det &&
     shift_ff == (alt_addr_ff ? 8'h41 : 8'h43)) |=> state_ff == vdr_pkg::ST_ACK_ADDR;
  endproperty
  a_rd_addr_ack: assert property (p_rd_addr_ack) else $error("read address not acknowledged"); // R02
  property p_strap;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(strap_done_ff) |-> alt_addr_ff == $past(REALTIME_CONTROL_OUTPUT_PIN);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured"); // R03
  property p_ptr_inc;
    @(posedge CLK_SYS) disable iff (RST)
    (wr_stb && !start_det && !stop_det) |=> ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance"); // R04
  property p_ack_hold;
    @(posedge CLK_SYS) disable iff (RST)
    (wr_stb && !start_det && !stop_det) |=> SDA_OE [*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data byte not acknowledged"); // R05
  property p_status_ro;
    @(posedge CLK_SYS) disable iff (RST)
    mem_ff[8'h1E] == 8'h00 && mem_ff[8'h1F] == 8'h00 && rbyte(8'h1E) == status_one;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status byte altered"); // R09
  property p_slicer_ro;
    @(posedge CLK_SYS) disable iff (RST)
    mem_ff[8'h60] == 8'h00 && mem_ff[8'h62] == 8'h00 && rbyte(8'h62) == SLICER_STATUS_2;
  endproperty
  a_slicer_ro: assert property (p_slicer_ro) else $error("slicer status altered"); // R10
  property p_reserved;
    @(posedge CLK_SYS) disable iff (RST)
    (wr_stb && ptr_ff == 8'h21) |=> mem_ff[8'h21] == 8'h00 && mem_ff[8'h23][3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte changed"); // R12
  property p_scaler_rw;
    @(posedge CLK_SYS) disable iff (RST)
    (wr_stb && ptr_ff == 8'h80) |=> mem_ff[8'h80] == $past(shift_ff);
  endproperty
  a_scaler_rw: assert property (p_scaler_rw) else $error("scaler byte not stored"); // R11
  c_write: cover property (@(posedge CLK_SYS) disable iff (RST) wr_stb);
  c_read: cover property (@(posedge CLK_SYS) disable iff (RST)
    state_ff == vdr_pkg::ST_MACK ##1 state_ff == vdr_pkg::ST_RDATA);
  c_alt: cover property (@(posedge CLK_SYS) disable iff (RST) alt_addr_ff && wr_stb);

endmodule : vdr_i2c_regs
`default_nettype wire

// File: core/vdr_pkg.sv
// Types shared by the video decoder register bank.
package vdr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_SUB = 4'b0011,
    ST_ACK_SUB = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_DATA = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_MACK = 4'b1000
  } vdr_state_t;
endpackage : vdr_pkg

// File: dv/vdr_bus_model.sv
// Two-wire bus master model that drives the register bank's bus pins.
`timescale 1ns/1ps
`default_nettype none
module vdr_bus_model (
  input wire logic clk, // System clock that paces the bus.
  input wire logic sda, // Resolved data wire level.
  output logic scl, // Bus clock, high while idle.
  output logic m_oe, // High while the master pulls data low.
  output logic got, // One-cycle pulse after each byte read.
  output logic [7:0] got_data // Byte just read.
);
  // The bus starts idle with both lines released.
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
    got = 1'b0;
    got_data = 8'h00;
  end
  // Waits n clock edges and steps just past the last one.
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  // One bit: data set while the clock is low, sampled mid-high.
  task automatic pulse(input logic b, output logic s);
    m_oe = !b;
    w(2);
    scl = 1'b1;
    w(2);
    s = sda;
    w(2);
    scl = 1'b0;
    w(2);
  endtask : pulse
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    m_oe = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    m_oe = 1'b1;
    w(4);
    scl = 1'b0;
    w(2);
  endtask : start
  // Stop: data rises while the clock is high, then the bus idles.
  task automatic stop();
    m_oe = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    m_oe = 1'b0;
    w(4);
  endtask : stop
  // Sends a byte from the top bit down and returns the slave's acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i], s);
    pulse(1'b1, s);
    ack = !s;
  endtask : wbyte
  // Reads a byte, then acknowledges it or not, and reports it.
  task automatic rbyte(input logic mack);
    logic s;
    logic [7:0] sh;
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, s);
      sh = {sh[6:0], s};
    end
    pulse(!mack, s);
    got_data = sh;
    got = 1'b1;
    w(1);
    got = 1'b0;
  endtask : rbyte
endmodule : vdr_bus_model
`default_nettype wire

// File: dv/vdr_i2c_regs_tb.sv
// Self-checking bench for the video decoder register bank.
`timescale 1ns/1ps
`default_nettype none
module vdr_i2c_regs_tb;
  logic clk, rst, strap, amc, scl, m_oe, got, ack, sda_oe, sda_out, pb, pw;
  logic [7:0] got_data, s1, s2, sl0, sl1, sl2, sa;
  logic [7:0] d[3];
  logic [7:0] exq[$];
  logic a_sel, a_port, a_xclk, a_ref, a_clamp, pll, mode, bclk, wclk;
  logic [8:0] g3, g4;
  logic [17:0] audio_cycles_per_field;
  logic [21:0] audio_nominal_increment;
  int failures, checks_done, seed, nb, nw, hb, hw;
  logic [7:0] subs[6] = '{8'h30, 8'h34, 8'h23, 8'h2D, 8'h20, 8'h80};
  logic [7:0] msk[6][3] = '{'{8'hFF, 8'hFF, 8'h03}, '{8'hFF, 8'hFF, 8'h3F},
    '{8'hF7, 8'hFF, 8'hFF}, '{8'h1D, 8'h43, 8'hEF}, '{8'h00, 8'h00, 8'h00},
    '{8'hFF, 8'hFF, 8'hFF}};
  wire sda;
  // The pulled-up data wire shows the slave's drive value while enabled and is low while the master pulls.
  assign sda = (sda_oe ? sda_out : 1'b1) & !m_oe;
  vdr_i2c_regs dut (.CLK_SYS(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .REALTIME_CONTROL_OUTPUT_PIN(strap),
    .HORIZONTAL_LOCK_FLAG(s1[6]), .SLOW_TIME_CONSTANT_FLAG(s1[5]),
    .GAIN_UPPER_LIMIT_FLAG(s1[4]), .GAIN_LOWER_LIMIT_FLAG(s1[3]),
    .WHITE_PEAK_FLAG(s1[2]), .DETECTED_STANDARD(s1[1:0]), .INTERLACE_FLAG(s2[7]),
    .HALF_LEVEL_FLAG(s2[6]), .FIELD_FLAG(s2[5]), .TYPE_FLAG(s2[3]),
    .COLOR_STRIPE_FLAG(s2[2]), .COPY_PROTECT_FLAG(s2[1]), .READY_FLAG(s2[0]),
    .SLICER_STATUS_0(sl0), .SLICER_STATUS_1(sl1), .SLICER_STATUS_2(sl2),
    .AUDIO_MASTER_CLOCK(amc), .ANALOG_OUTPUT_SELECT_BIT(a_sel),
    .CONVERTER_PORT_ENABLE(a_port), .EXTERNAL_CLOCK_SELECT(a_xclk),
    .REFERENCE_SELECT(a_ref), .EXTERNAL_CLAMP_ENABLE(a_clamp), .CHANNEL_THREE_GAIN(g3),
    .CHANNEL_FOUR_GAIN(g4), .AUDIO_CYCLES_PER_FIELD(audio_cycles_per_field), .AUDIO_NOMINAL_INCREMENT(audio_nominal_increment),
    .AUDIO_PLL_CONTROL(pll), .MASTER_CLOCK_MODE(mode), .AUDIO_BIT_CLOCK(bclk),
    .AUDIO_WORD_CLOCK(wclk));
  vdr_bus_model u_bm (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe), .got(got),
    .got_data(got_data));
  // System clock and an audio master clock of six system periods.
  always #2 clk = ~clk;
  always begin
    repeat (3) @(posedge clk);
    #1;
    amc = ~amc;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Each byte read on the bus is matched with the oldest expectation.
  always @(posedge clk) begin
    if (got === 1'b1) begin
      if (exq.size() == 0) chk("rd_unexpected", 32'h0, 32'h1);
      else chk("rd_byte", {24'h0, exq.pop_front()}, {24'h0, got_data});
    end
  end
  task automatic wr(input logic [7:0] sub, input int cnt);
    u_bm.start();
    u_bm.wbyte(sa, ack);
    chk("ack_wr_addr", 32'h1, {31'h0, ack});
    u_bm.wbyte(sub, ack);
    chk("ack_sub", 32'h1, {31'h0, ack});
    for (int i = 0; i < cnt; i++) begin
      u_bm.wbyte(d[i], ack);
      chk("ack_data", 32'h1, {31'h0, ack});
    end
    u_bm.stop();
  endtask : wr
  task automatic rd(input logic [7:0] sub, input int cnt);
    u_bm.start();
    u_bm.wbyte(sa, ack);
    u_bm.wbyte(sub, ack);
    u_bm.start();
    u_bm.wbyte(sa | 8'h01, ack);
    chk("ack_rd_addr", 32'h1, {31'h0, ack});
    for (int i = 0; i < cnt; i++) u_bm.rbyte(i < cnt - 1);
    u_bm.stop();
    chk("rd_left", 32'h0, exq.size());
  endtask : rd
  task automatic do_reset(input logic st);
    rst = 1'b1;
    strap = st;
    sa = st ? 8'h40 : 8'h42;
    u_bm.w(10);
    rst = 1'b0;
    u_bm.w(4);
  endtask : do_reset
  task automatic end_sim();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // Main sequence.
  initial begin
    clk = 1'b0;
    amc = 1'b0;
    seed = 91523;
    failures = 0;
    checks_done = 0;
    s1 = 8'h00;
    s2 = 8'h00;
    sl0 = 8'h00;
    sl1 = 8'h00;
    sl2 = 8'h00;
    do_reset(1'b0);
    exq.push_back(8'h11);
    rd(8'h00, 1);
    exq.push_back(8'h00);
    exq.push_back(8'h00);
    rd(8'h2A, 2);
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
      wr(subs[k], 3);
      for (int i = 0; i < 3; i++) exq.push_back(d[i] & msk[k][i]);
      rd(subs[k], 3);
      if (k == 0) chk("audio_cycles_per_field", {14'h0, d[2][1:0], d[1], d[0]}, {14'h0, audio_cycles_per_field});
      if (k == 1) chk("audio_nominal_increment", {10'h0, d[2][5:0], d[1], d[0]}, {10'h0, audio_nominal_increment});
      if (k == 2) begin
        chk("gain3", {23'h0, d[0][0], d[1]}, {23'h0, g3});
        chk("gain4", {23'h0, d[0][1], d[2]}, {23'h0, g4});
        chk("ana_bits", {27'h0, d[0][7:4], d[0][2]},
          {27'h0, a_sel, a_port, a_xclk, a_ref, a_clamp});
      end
    end
    // Three random status patterns; writing FFh over the status bytes must not change what reads back.
    for (int j = 0; j < 3; j++) begin
      s1 = 8'($random(seed));
      s2 = 8'($random(seed));
      sl0 = 8'($random(seed));
      sl1 = 8'($random(seed));
      sl2 = 8'($random(seed));
      d = '{8'hFF, 8'hFF, 8'hFF};
      wr(8'h1E, 2);
      exq.push_back(s1 & 8'h7F);
      exq.push_back(s2 & 8'hEF);
      rd(8'h1E, 2);
      wr(8'h60, 3);
      exq.push_back(sl0);
      exq.push_back(sl1);
      exq.push_back(sl2);
      rd(8'h60, 3);
    end
    // Odd ratios give an uneven duty, so the phase bits show in the high time.
    d = '{8'h05, 8'h03, 8'($random(seed))};
    wr(8'h38, 3);
    exq.push_back(8'h05);
    exq.push_back(8'h03);
    exq.push_back(d[2] & 8'h0F);
    rd(8'h38, 3);
    chk("pll_mode", {30'h0, d[2][3:2]}, {30'h0, pll, mode});
    nb = 0;
    nw = 0;
    hb = 0;
    hw = 0;
    for (int i = 0; i < 720; i++) begin
      pb = bclk;
      pw = wclk;
      u_bm.w(1);
      if (bclk && !pb) nb++;
      if (wclk && !pw) nw++;
      if (bclk) hb++;
      if (wclk) hw++;
    end
    chk("bit_clk_rate", 32'h1, {31'h0, nb >= 23 && nb <= 25});
    chk("word_clk_rate", 32'h1, {31'h0, nw >= 7 && nw <= 9});
    chk("bit_clk_high", d[2][0] ? 32'h0000_01B0 : 32'h0000_0120, hb);
    chk("word_clk_high", d[2][1] ? 32'h0000_01E0 : 32'h0000_00F0, hw);
    u_bm.start();
    u_bm.wbyte(8'h40, ack);
    chk("nack_alt", 32'h0, {31'h0, ack});
    u_bm.stop();
    do_reset(1'b1);
    exq.push_back(8'h11);
    rd(8'h00, 1);
    u_bm.start();
    u_bm.wbyte(8'h42, ack);
    chk("nack_def", 32'h0, {31'h0, ack});
    u_bm.stop();
    end_sim();
  end
  // A hang is cut short as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    chk("timeout", 32'h0, 32'h1);
    end_sim();
  end
endmodule : vdr_i2c_regs_tb
`default_nettype wire
